// File: add_sub_pkg.sv
//==========================================================
// add_sub_pkg: constants for the fixed-point adder
//==========================================================
// Summary of operation
// - first step stores accumulator XOR buffer
// - partial 0, buffer 1 complements next bit
// - least significant bit never changed by an add carry pass
// - complementing 1 to 0 ripples onward
// - sign bit joins the exclusive OR
// - carry functions extend into sign bit
// - sign carry out when signs force it
// - overflow when bit1 and bit0 carries differ
// - operands are sign-at-bit-0 two's fractions
// - opposite signs never overflow an add
// - subtract inverts, adds, inverts again
// - subtracting minus one flags overflow right
package add_sub_pkg;
	// word width, sign at bit 0, lsb at bit 35
	localparam int WORD_W = 36;
	// sign position and the most significant magnitude bit
	localparam int SIGN_POS = 0;
	localparam int MAG_TOP_POS = 1;
	// accumulator reset value
	localparam logic [WORD_W-1:0] ACC_RESET = 36'h000000000;
	// sequencing states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CARRY,
		ST_FINAL
	} seq_state_t;
endpackage

// File: control_sequence_model.sv
`timescale 1ns/1ps
//==========================================================
// control_sequence_model: main sequence pulse chain
//==========================================================
module control_sequence_model (
	// clock
	input wire logic ref_clk,
	// requests from the bench
	input wire logic go,
	input wire logic go_sub,
	input wire logic gap,
	// pulses to the adder
	output logic add_sub_first_pulse,
	output logic carry_pulse,
	output logic subtract
);
	// gap delays the carry one cycle, which the adder must ignore
	initial begin
		add_sub_first_pulse = 1'b0;
		carry_pulse = 1'b0;
		subtract = 1'b0;
		forever begin
			@(posedge ref_clk);
			if (go === 1'b1) begin
				#2 add_sub_first_pulse = 1'b1;
				subtract = go_sub;
				@(posedge ref_clk);
				#2 add_sub_first_pulse = 1'b0;
				if (gap === 1'b1) begin
					@(posedge ref_clk);
					#2;
				end
				carry_pulse = 1'b1;
				@(posedge ref_clk);
				#2 carry_pulse = 1'b0;
			end
		end
	end
endmodule

// File: twos_complement_add_subtract.sv
`timescale 1ns/1ps
//==========================================================
// twos_complement_add_subtract: two-step adder datapath
//==========================================================
// bit 0 is the sign (msb), bit 35 the lsb; vectors are [0:35]
module twos_complement_add_subtract (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// control pulses from the main sequence
	input wire logic load_pulse,
	input wire logic [0:add_sub_pkg::WORD_W-1] load_word,
	input wire logic add_sub_first_pulse,
	input wire logic carry_pulse,
	input wire logic subtract,
	// operand held by the memory buffer
	input wire logic [0:add_sub_pkg::WORD_W-1] memory_buffer_word,
	// results
	output logic [0:add_sub_pkg::WORD_W-1] accumulator_word,
	output logic carry_out_bit1,
	output logic carry_out_bit0,
	output logic overflow,
	output logic done
);
	import add_sub_pkg::*;

	//======================================================
	// state
	//======================================================
	logic [0:WORD_W-1] acc_q; // accumulator word, sign first
	logic [0:WORD_W-1] acc_d;
	logic c1_q; // carry out of bit 1
	logic c0_q; // carry out of sign bit
	logic ov_q; // overflow flag
	logic done_q; // result ready pulse
	logic sub_q; // subtraction in progress
	seq_state_t st_q;

	//======================================================
	// carry chain: carry into bit i comes from bit i+1
	//======================================================
	// cin[i] is the carry leaving position i into i-1; cin[WORD_W] is none
	logic [0:WORD_W] cin;
	logic [0:WORD_W-1] gen; // carry initiate: ps 0 with buffer 1
	logic [0:WORD_W-1] cout; // carry leaving position i
	logic [0:WORD_W-1] summed;
	assign cin[WORD_W] = 1'b0;
	genvar gi;
	generate
		for (gi = 0; gi < WORD_W; gi = gi + 1) begin : g_bit
			// a 0 partial bit under a 1 buffer bit means both were 1
			assign gen[gi] = ~acc_q[gi] & memory_buffer_word[gi];
			// an incoming carry on a 1 bit ripples; stops on a 0
			assign cout[gi] = gen[gi] | (cin[gi+1] & acc_q[gi]);
			assign cin[gi] = cout[gi];
			assign summed[gi] = acc_q[gi] ^ cin[gi+1];
		end
	endgenerate

	// the sign bit is just the top of the chain, no special case
	wire carry_b1 = cout[MAG_TOP_POS];
	wire carry_b0 = cout[SIGN_POS];
	wire [0:WORD_W-1] xor_word = acc_q ^ memory_buffer_word;
	wire start_cmp = add_sub_first_pulse & subtract;

	//======================================================
	// accumulator next value
	//======================================================
	always_comb begin
		acc_d = acc_q;
		if (load_pulse) begin
			acc_d = load_word;
		end else if (add_sub_first_pulse) begin
			// subtract: complement first, then partial add
			acc_d = start_cmp ? (~acc_q ^ memory_buffer_word)
				: xor_word;
		end else if (carry_pulse && st_q == ST_CARRY) begin
			acc_d = sub_q ? ~summed : summed;
		end
	end

	// the carry pass runs combinationally in one cycle: the
	// whole 36-bit ripple must fit in 20 ns, a timing trade-off
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			acc_q <= ACC_RESET;
			c1_q <= 1'b0;
			c0_q <= 1'b0;
			ov_q <= 1'b0;
			done_q <= 1'b0;
			sub_q <= 1'b0;
			st_q <= ST_IDLE;
		end else begin
			acc_q <= acc_d;
			done_q <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					// partial step; carry must follow next pulse
					if (add_sub_first_pulse) begin
						sub_q <= subtract;
						st_q <= ST_CARRY;
					end
				end
				ST_CARRY: begin
					if (carry_pulse) begin
						// flags latch the carries of this very pass
						c1_q <= carry_b1;
						c0_q <= carry_b0;
						ov_q <= carry_b1 ^ carry_b0;
						done_q <= 1'b1;
						st_q <= ST_FINAL;
					end else if (!add_sub_first_pulse) begin
						// missing carry pulse abandons the add
						st_q <= ST_IDLE;
					end
				end
				default: begin
					// a new first pulse may follow the carry pass at once
					st_q <= add_sub_first_pulse ? ST_CARRY : ST_IDLE;
					if (add_sub_first_pulse) begin
						sub_q <= subtract;
					end
				end
			endcase
		end
	end

	// outputs come straight from the registers, so the flag logic
	// downstream sees no ripple glitches from the carry chain
	assign accumulator_word = acc_q;
	assign carry_out_bit1 = c1_q;
	assign carry_out_bit0 = c0_q;
	assign overflow = ov_q;
	assign done = done_q;

	//======================================================
	// checks
	//======================================================
	// the lsb after an add carry pass equals the partial sum lsb
	AST_LSB_FINAL: assert property (@(posedge ref_clk) disable iff (!nrst)
		(st_q == ST_CARRY && carry_pulse && !load_pulse && !sub_q)
		|=> acc_q[WORD_W-1] == $past(acc_q[WORD_W-1]))
		else $error("lsb altered by carry");
	// overflow equals carry mismatch
	AST_OVF: assert property (@(posedge ref_clk) disable iff (!nrst)
		done_q |-> ov_q == (c1_q ^ c0_q))
		else $error("overflow not carry mismatch");
	// partial step leaves the xor
	AST_PARTIAL: assert property (@(posedge ref_clk) disable iff (!nrst)
		(add_sub_first_pulse && !subtract && !load_pulse)
		|=> acc_q == $past(acc_q ^ memory_buffer_word))
		else $error("partial sum wrong");
	// add result is the true sum of the operands
	AST_SUM: assert property (@(posedge ref_clk) disable iff (!nrst)
		(add_sub_first_pulse && !subtract && !load_pulse) ##1
		(carry_pulse && !load_pulse && !add_sub_first_pulse)
		|=> acc_q == 36'($past(acc_q, 2) + $past(memory_buffer_word, 2)))
		else $error("sum wrong");
	// opposite signs never overflow
	AST_NO_OVF: assert property (@(posedge ref_clk) disable iff (!nrst)
		(add_sub_first_pulse && !subtract && !load_pulse
		&& (acc_q[SIGN_POS] != memory_buffer_word[SIGN_POS])) ##1
		(carry_pulse && !add_sub_first_pulse) |=> !ov_q)
		else $error("overflow on opposite signs");
	// subtract result is the difference
	AST_SUB: assert property (@(posedge ref_clk) disable iff (!nrst)
		(start_cmp && !load_pulse) ##1
		(carry_pulse && !load_pulse && !add_sub_first_pulse)
		|=> acc_q == 36'($past(acc_q, 2) - $past(memory_buffer_word, 2)))
		else $error("difference wrong");
	// done one cycle after accepted carry pulse
	AST_DONE: assert property (@(posedge ref_clk) disable iff (!nrst)
		(st_q == ST_CARRY && carry_pulse) |=> done_q)
		else $error("done missing");
	// two negative operands carry out of the sign
	AST_SIGN_CARRY: assert property (@(posedge ref_clk) disable iff (!nrst)
		(add_sub_first_pulse && !subtract && !load_pulse
		&& acc_q[SIGN_POS] && memory_buffer_word[SIGN_POS]) ##1
		(carry_pulse && !add_sub_first_pulse) |=> c0_q)
		else $error("no sign carry for two negatives");

	//======================================================
	// checks against the signed meaning of the flags
	//======================================================
	// add overflow: equal operand signs, result sign flipped
	AST_OVF_ADD: assert property (@(posedge ref_clk) disable iff (!nrst)
		(add_sub_first_pulse && !subtract && !load_pulse) ##1
		(carry_pulse && !load_pulse && !add_sub_first_pulse)
		|=> ov_q == (($past(acc_q[SIGN_POS], 2)
		== $past(memory_buffer_word[SIGN_POS], 2))
		&& (acc_q[SIGN_POS] != $past(acc_q[SIGN_POS], 2))))
		else $error("add overflow does not match signs");
	// subtract overflow: operand signs differ, result sign flipped;
	// holds for minus one too, since the complement form reaches it
	AST_OVF_SUB: assert property (@(posedge ref_clk) disable iff (!nrst)
		(start_cmp && !load_pulse) ##1
		(carry_pulse && !load_pulse && !add_sub_first_pulse)
		|=> ov_q == (($past(acc_q[SIGN_POS], 2)
		!= $past(memory_buffer_word[SIGN_POS], 2))
		&& (acc_q[SIGN_POS] != $past(acc_q[SIGN_POS], 2))))
		else $error("subtract overflow does not match signs");
	// a carry from bit 1 into a 1 sign clears it and leaves bit 0
	AST_RIPPLE0: assert property (@(posedge ref_clk) disable iff (!nrst)
		(st_q == ST_CARRY && carry_pulse && !sub_q && !load_pulse
		&& !add_sub_first_pulse && carry_b1 && acc_q[SIGN_POS])
		|=> c0_q && !acc_q[SIGN_POS])
		else $error("bit 1 carry did not ripple through sign");
	// partial 0 under buffer 1 at the sign starts a carry out of it
	AST_INIT0: assert property (@(posedge ref_clk) disable iff (!nrst)
		(st_q == ST_CARRY && carry_pulse && !load_pulse
		&& !add_sub_first_pulse && !acc_q[SIGN_POS]
		&& memory_buffer_word[SIGN_POS]) |=> c0_q)
		else $error("carry initiate missing at sign");
	// a carry pulse one cycle late is refused: no change, no done
	AST_LATE: assert property (@(posedge ref_clk) disable iff (!nrst)
		(add_sub_first_pulse && !load_pulse) ##1
		(!carry_pulse && !add_sub_first_pulse && !load_pulse) ##1
		(carry_pulse && !add_sub_first_pulse && !load_pulse)
		|=> $stable(acc_q) && !done_q)
		else $error("late carry pulse acted on");
	// flags change only at an accepted carry pass
	AST_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		!(st_q == ST_CARRY && carry_pulse)
		|=> $stable(c1_q) && $stable(c0_q) && $stable(ov_q))
		else $error("carry flags changed outside a carry pass");
endmodule

// File: twos_complement_add_subtract_tb.sv
`timescale 1ns/1ps
//==========================================================
// twos_complement_add_subtract_tb: directed checks
//==========================================================
module twos_complement_add_subtract_tb;
	logic ref_clk = 1'b0, nrst = 1'b0, load_pulse = 1'b0;
	logic go = 1'b0, go_sub = 1'b0, gap = 1'b0;
	logic first_p, carry_p, sub;
	logic [0:35] load_word = 36'h0, mb = 36'h0, acc;
	logic c1_o, c0_o, ovf_o, done_o;
	int failures = 0, checked = 0, cycles = 0;
	control_sequence_model seq (.ref_clk(ref_clk), .go(go),
		.go_sub(go_sub), .gap(gap), .add_sub_first_pulse(first_p),
		.carry_pulse(carry_p), .subtract(sub));
	twos_complement_add_subtract uut (.ref_clk(ref_clk), .nrst(nrst),
		.load_pulse(load_pulse), .load_word(load_word),
		.add_sub_first_pulse(first_p), .carry_pulse(carry_p),
		.subtract(sub), .memory_buffer_word(mb),
		.accumulator_word(acc), .carry_out_bit1(c1_o),
		.carry_out_bit0(c0_o), .overflow(ovf_o), .done(done_o));
	// 50 MHz clock; a hang is cut short well past the expected run
	initial forever #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			finish_test();
		end
	end
	task automatic check(input logic [35:0] seen, exp, input string m);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	// one load then one operation; expectations from plain arithmetic
	task automatic op(input logic [0:35] a, b, input logic s, g);
		logic [0:35] x;
		logic [36:0] t;
		logic [35:0] u;
		x = s ? ~a : a;
		t = {1'b0, x} + {1'b0, b};
		u = {1'b0, x[1:35]} + {1'b0, b[1:35]};
		load_word = a;
		load_pulse = 1'b1;
		@(posedge ref_clk);
		#2 load_pulse = 1'b0;
		mb = b;
		go = 1'b1;
		go_sub = s;
		gap = g;
		@(posedge ref_clk);
		#2 go = 1'b0;
		@(posedge ref_clk);
		#2 check(acc, x ^ b, "partial sum");
		@(posedge ref_clk);
		if (g) begin
			@(posedge ref_clk);
			@(posedge ref_clk);
			#2 check(acc, x ^ b, "late carry acted on");
			check(done_o, 1'b0, "done on late carry");
		end else begin
			#2 check(acc, s ? ~t[35:0] : t[35:0], "result");
			check(c1_o, u[35], "carry out of bit 1");
			check(c0_o, t[36], "carry out of sign");
			check(ovf_o, u[35] ^ t[36], "overflow");
			check(done_o, 1'b1, "done missing");
			@(posedge ref_clk);
			#2 check(done_o, 1'b0, "done too long");
		end
	endtask
	// low bits carry up; bit 35 stays as partial
	task automatic t_ripple();
		op(36'h0000000FF, 36'h000000001, 1'b0, 1'b0);
		op(36'h400000000, 36'h400000000, 1'b0, 1'b0);
		$display("test ripple done");
	endtask
	// negative pairs: sign in xor and carries
	task automatic t_neg();
		op(36'h800000000, 36'h800000000, 1'b0, 1'b0);
		op(36'hFFFFFFFFF, 36'hFFFFFFFFF, 1'b0, 1'b0);
		$display("test negatives done");
	endtask
	// opposite signs never overflow
	task automatic t_mixed();
		op(36'h000000010, 36'hFFFFFFFF0, 1'b0, 1'b0);
		op(36'h000000010, 36'hFFFFFFFE0, 1'b0, 1'b0);
		$display("test mixed done");
	endtask
	// subtraction, minus one included
	task automatic t_sub();
		op(36'h000000005, 36'h000000003, 1'b1, 1'b0);
		op(36'h000000000, 36'h800000000, 1'b1, 1'b0);
		$display("test subtract done");
	endtask
	// carry one cycle late is refused
	task automatic t_gap();
		op(36'h000000003, 36'h000000001, 1'b0, 1'b1);
		$display("test late carry done");
	endtask
	task automatic finish_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		#2 nrst = 1'b1;
		t_ripple();
		t_neg();
		t_mixed();
		t_sub();
		t_gap();
		finish_test();
	end
endmodule
